// *** gpjn_map.svh ***
// Purpose: offsets, field positions and reset values of the port J to N block
// Assumes: a register index times four gives its APB byte address
// Notes: only the low ten bits of an index reach the address decoder
`ifndef GPJN_MAP_SVH
`define GPJN_MAP_SVH

// register indices, byte address is four times the index
`define GPJN_IDX_J_DATA       32'hffff_f070
`define GPJN_IDX_K_DATA       32'hffff_f071
`define GPJN_IDX_J_DIR        32'hffff_f074
`define GPJN_IDX_K_DIR        32'hffff_f075
`define GPJN_IDX_J_FUNC       32'hffff_f078
`define GPJN_IDX_K_FUNC       32'hffff_f079
`define GPJN_IDX_L_DATA       32'hffff_f0c0
`define GPJN_IDX_M_DATA       32'hffff_f0c1
`define GPJN_IDX_N_DATA       32'hffff_f0c2
`define GPJN_IDX_L_DIR        32'hffff_f0c4
`define GPJN_IDX_M_DIR        32'hffff_f0c5
`define GPJN_IDX_N_DIR        32'hffff_f0c6
`define GPJN_IDX_STOP_CTRL    32'hffff_f0f8

// reset values
`define GPJN_LATCH_FILL       1'b1
`define GPJN_DIR_FILL         1'b0
`define GPJN_FUNC_RESET       8'h00
`define GPJN_STOP_DRIVE_RESET 1'b0

// field positions
`define GPJN_STOP_DRIVE_BIT   0
`define GPJN_J_REQ2_BIT       0
`define GPJN_J_ACK2_BIT       1
`define GPJN_J_REQ3_BIT       2
`define GPJN_J_ACK3_BIT       3

// idle levels of routed signals
`define GPJN_DMA_IDLE         1'b1
`define GPJN_KEY_IDLE         8'hff

`endif

// *** gpjn_pkg.sv ***
// Purpose: shared types of the port J to N block
// Assumes: nothing beyond the map header
// Notes: register selector decoded from the APB address
package gpjn_pkg;

    typedef logic [7:0] gpjn_byte_type;

    typedef enum {
        gpjn_sel_none,
        gpjn_sel_j_data,
        gpjn_sel_k_data,
        gpjn_sel_j_dir,
        gpjn_sel_k_dir,
        gpjn_sel_j_func,
        gpjn_sel_k_func,
        gpjn_sel_l_data,
        gpjn_sel_m_data,
        gpjn_sel_n_data,
        gpjn_sel_l_dir,
        gpjn_sel_m_dir,
        gpjn_sel_n_dir,
        gpjn_sel_stop_ctrl
    } gpjn_reg_sel_type;

endpackage

// *** gpjn_port_slice.sv ***
// Purpose: one parallel port: output latch, direction register, pin drivers
// Assumes: pin inputs are synchronous to pclk
// Notes: pin drivers are registered, so they lag a register write by one cycle
`timescale 1ns/1ps
`include "gpjn_map.svh"

module gpjn_port_slice #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         data_wr,
    input  wire logic         dir_wr,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] alt_sel,
    input  wire logic [W-1:0] alt_out,
    input  wire logic         stop_float,
    output logic      [W-1:0] rd_data,
    output logic      [W-1:0] dir,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe
);
    import gpjn_pkg::*;

    logic [W-1:0] latch;

    // output latch, written whatever the direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch <= {W{`GPJN_LATCH_FILL}};
        end else if (data_wr) begin
            latch <= wdata;
        end
    end

    // per-bit direction, 1 drives the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir <= {W{`GPJN_DIR_FILL}};
        end else if (dir_wr) begin
            dir <= wdata;
        end
    end

    // pin drivers, alternate function replaces the latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= {W{`GPJN_LATCH_FILL}};
            pin_oe  <= {W{`GPJN_DIR_FILL}};
        end else begin
            pin_out <= (alt_sel & alt_out) | (~alt_sel & latch);
            pin_oe  <= stop_float ? {W{`GPJN_DIR_FILL}} : dir;
        end
    end

    // read back: pin for inputs, latch for outputs
    assign rd_data = (dir & latch) | (~dir & pin_in);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    latch_write_kept_a: assert property (
        data_wr && !$past(data_wr) ##1 !data_wr ##0 (dir == {W{1'b1}}) && !dir_wr
            |-> rd_data == $past(wdata, 1)
    ) else $error("latch lost written value");

    oe_stop_float_a: assert property (
        stop_float |=> pin_oe == '0
    ) else $error("pin driven while floating in stop");

endmodule // gpjn_port_slice

// *** gpjn_ports.sv ***
// What this block does
// - port J function bits route DMA signals
// - port F wins shared DMA signals
// - port K eight bits, per-bit direction
// - reset clears port K direction, function
// - port K function bit feeds key input
// - pull-up needs enable and wake setting
// - pull-up off while pins are ports
// - reset sets output latches to ones
// - port L eight bits, per-bit direction
// - reset clears port L direction
// - port M eight bits, per-bit direction
// - reset clears port M direction
// - port N direction register, reset cleared
//
// Purpose: general-purpose ports J, K, L, M and N behind an APB slave
// Assumes: pins and outside controls are synchronous to pclk
// Notes: every access takes one setup and one access cycle, no wait states
`timescale 1ns/1ps
`include "gpjn_map.svh"

module gpjn_ports #(
    parameter int ADDR_W = 12
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [3:0]            port_j_pin_in,
    output logic      [3:0]            port_j_pin_out,
    output logic      [3:0]            port_j_pin_oe,
    input  wire gpjn_pkg::gpjn_byte_type port_k_pin_in,
    output gpjn_pkg::gpjn_byte_type    port_k_pin_out,
    output gpjn_pkg::gpjn_byte_type    port_k_pin_oe,
    input  wire gpjn_pkg::gpjn_byte_type port_l_pin_in,
    output gpjn_pkg::gpjn_byte_type    port_l_pin_out,
    output gpjn_pkg::gpjn_byte_type    port_l_pin_oe,
    input  wire gpjn_pkg::gpjn_byte_type port_m_pin_in,
    output gpjn_pkg::gpjn_byte_type    port_m_pin_out,
    output gpjn_pkg::gpjn_byte_type    port_m_pin_oe,
    input  wire gpjn_pkg::gpjn_byte_type port_n_pin_in,
    output gpjn_pkg::gpjn_byte_type    port_n_pin_out,
    output gpjn_pkg::gpjn_byte_type    port_n_pin_oe,
    input  wire logic                  stop_mode,
    input  wire logic [3:0]            port_f_dma_claim,
    input  wire logic                  dma_acknowledge_ch2_out,
    input  wire logic                  dma_acknowledge_ch3_out,
    output logic                       dma_request_ch2_in,
    output logic                       dma_request_ch3_in,
    input  wire gpjn_pkg::gpjn_byte_type wake_pullup_enable,
    input  wire gpjn_pkg::gpjn_byte_type wake_input_setting,
    output gpjn_pkg::gpjn_byte_type    wake_switch_input,
    output gpjn_pkg::gpjn_byte_type    port_k_pullup_on
);
    import gpjn_pkg::*;

    localparam logic [31:0] IDX_J_DATA = `GPJN_IDX_J_DATA;
    localparam logic [31:0] IDX_K_DATA = `GPJN_IDX_K_DATA;
    localparam logic [31:0] IDX_J_DIR  = `GPJN_IDX_J_DIR;
    localparam logic [31:0] IDX_K_DIR  = `GPJN_IDX_K_DIR;
    localparam logic [31:0] IDX_J_FUNC = `GPJN_IDX_J_FUNC;
    localparam logic [31:0] IDX_K_FUNC = `GPJN_IDX_K_FUNC;
    localparam logic [31:0] IDX_L_DATA = `GPJN_IDX_L_DATA;
    localparam logic [31:0] IDX_M_DATA = `GPJN_IDX_M_DATA;
    localparam logic [31:0] IDX_N_DATA = `GPJN_IDX_N_DATA;
    localparam logic [31:0] IDX_L_DIR  = `GPJN_IDX_L_DIR;
    localparam logic [31:0] IDX_M_DIR  = `GPJN_IDX_M_DIR;
    localparam logic [31:0] IDX_N_DIR  = `GPJN_IDX_N_DIR;
    localparam logic [31:0] IDX_STOP   = `GPJN_IDX_STOP_CTRL;

    gpjn_reg_sel_type sel;
    gpjn_byte_type    rd_mux;
    gpjn_byte_type    port_j_alt_function;
    gpjn_byte_type    port_k_alt_function;
    logic             stop_drive_enable;
    logic             stop_float;
    logic             wr;
    logic [3:0]       j_alt_sel;
    logic [3:0]       j_alt_out;
    logic [3:0]       j_rd;
    logic [3:0]       port_j_direction;
    gpjn_byte_type    k_rd;
    gpjn_byte_type    l_rd;
    gpjn_byte_type    m_rd;
    gpjn_byte_type    n_rd;
    gpjn_byte_type    port_k_direction;
    gpjn_byte_type    port_l_direction;
    gpjn_byte_type    port_m_direction;
    gpjn_byte_type    port_n_direction;

    // address decode on the word index
    always_comb begin
        unique case (paddr[ADDR_W-1:2])
            IDX_J_DATA[ADDR_W-3:0]: sel = gpjn_sel_j_data;
            IDX_K_DATA[ADDR_W-3:0]: sel = gpjn_sel_k_data;
            IDX_J_DIR[ADDR_W-3:0]:  sel = gpjn_sel_j_dir;
            IDX_K_DIR[ADDR_W-3:0]:  sel = gpjn_sel_k_dir;
            IDX_J_FUNC[ADDR_W-3:0]: sel = gpjn_sel_j_func;
            IDX_K_FUNC[ADDR_W-3:0]: sel = gpjn_sel_k_func;
            IDX_L_DATA[ADDR_W-3:0]: sel = gpjn_sel_l_data;
            IDX_M_DATA[ADDR_W-3:0]: sel = gpjn_sel_m_data;
            IDX_N_DATA[ADDR_W-3:0]: sel = gpjn_sel_n_data;
            IDX_L_DIR[ADDR_W-3:0]:  sel = gpjn_sel_l_dir;
            IDX_M_DIR[ADDR_W-3:0]:  sel = gpjn_sel_m_dir;
            IDX_N_DIR[ADDR_W-3:0]:  sel = gpjn_sel_n_dir;
            IDX_STOP[ADDR_W-3:0]:   sel = gpjn_sel_stop_ctrl;
            default:                sel = gpjn_sel_none;
        endcase
    end

    // read multiplexer, unused upper bits read zero
    always_comb begin
        unique case (sel)
            gpjn_sel_j_data:    rd_mux = {4'h0, j_rd};
            gpjn_sel_k_data:    rd_mux = k_rd;
            gpjn_sel_j_dir:     rd_mux = {4'h0, port_j_direction};
            gpjn_sel_k_dir:     rd_mux = port_k_direction;
            gpjn_sel_j_func:    rd_mux = port_j_alt_function;
            gpjn_sel_k_func:    rd_mux = port_k_alt_function;
            gpjn_sel_l_data:    rd_mux = l_rd;
            gpjn_sel_m_data:    rd_mux = m_rd;
            gpjn_sel_n_data:    rd_mux = n_rd;
            gpjn_sel_l_dir:     rd_mux = port_l_direction;
            gpjn_sel_m_dir:     rd_mux = port_m_direction;
            gpjn_sel_n_dir:     rd_mux = port_n_direction;
            gpjn_sel_stop_ctrl: rd_mux = {7'h00, stop_drive_enable};
            gpjn_sel_none:      rd_mux = 8'h00;
        endcase
    end

    // write strobe at the completing access edge, low lane only
    assign wr = psel && penable && pready && pwrite && pstrb[0] && (sel != gpjn_sel_none);

    // apb answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= (sel == gpjn_sel_none);
            prdata  <= {24'h00_0000, rd_mux};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // function registers, port J keeps only four bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_j_alt_function <= `GPJN_FUNC_RESET;
            port_k_alt_function <= `GPJN_FUNC_RESET;
        end else if (wr && sel == gpjn_sel_j_func) begin
            port_j_alt_function <= {4'h0, pwdata[3:0]};
        end else if (wr && sel == gpjn_sel_k_func) begin
            port_k_alt_function <= pwdata[7:0];
        end
    end

    // stop drive control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_drive_enable <= `GPJN_STOP_DRIVE_RESET;
        end else if (wr && sel == gpjn_sel_stop_ctrl) begin
            stop_drive_enable <= pwdata[`GPJN_STOP_DRIVE_BIT];
        end
    end

    assign stop_float = stop_mode && !stop_drive_enable;

    // port J routing, port F claim takes the signal away
    assign j_alt_sel = port_j_alt_function[3:0] & ~port_f_dma_claim;
    assign j_alt_out = {dma_acknowledge_ch3_out, 1'b0, dma_acknowledge_ch2_out, 1'b0};

    // dma requests to the controller, idle when not routed here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_request_ch2_in <= `GPJN_DMA_IDLE;
            dma_request_ch3_in <= `GPJN_DMA_IDLE;
        end else begin
            dma_request_ch2_in <= j_alt_sel[`GPJN_J_REQ2_BIT] ?
                                  port_j_pin_in[`GPJN_J_REQ2_BIT] : `GPJN_DMA_IDLE;
            dma_request_ch3_in <= j_alt_sel[`GPJN_J_REQ3_BIT] ?
                                  port_j_pin_in[`GPJN_J_REQ3_BIT] : `GPJN_DMA_IDLE;
        end
    end

    // key inputs and pull-ups of port K
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_switch_input <= `GPJN_KEY_IDLE;
            port_k_pullup_on  <= `GPJN_FUNC_RESET;
        end else begin
            wake_switch_input <= (port_k_alt_function & port_k_pin_in) |
                                 (~port_k_alt_function & `GPJN_KEY_IDLE);
            port_k_pullup_on  <= wake_pullup_enable & wake_input_setting &
                                 port_k_alt_function;
        end
    end

    // port slices
    gpjn_port_slice #(.W(4)) u_port_j (
        .pclk       (pclk),
        .presetn    (presetn),
        .data_wr    (wr && sel == gpjn_sel_j_data),
        .dir_wr     (wr && sel == gpjn_sel_j_dir),
        .wdata      (pwdata[3:0]),
        .pin_in     (port_j_pin_in),
        .alt_sel    (j_alt_sel),
        .alt_out    (j_alt_out),
        .stop_float (stop_float),
        .rd_data    (j_rd),
        .dir        (port_j_direction),
        .pin_out    (port_j_pin_out),
        .pin_oe     (port_j_pin_oe)
    );

    gpjn_port_slice #(.W(8)) u_port_k (
        .pclk       (pclk),
        .presetn    (presetn),
        .data_wr    (wr && sel == gpjn_sel_k_data),
        .dir_wr     (wr && sel == gpjn_sel_k_dir),
        .wdata      (pwdata[7:0]),
        .pin_in     (port_k_pin_in),
        .alt_sel    (8'h00),
        .alt_out    (8'h00),
        .stop_float (stop_float),
        .rd_data    (k_rd),
        .dir        (port_k_direction),
        .pin_out    (port_k_pin_out),
        .pin_oe     (port_k_pin_oe)
    );

    gpjn_port_slice #(.W(8)) u_port_l (
        .pclk       (pclk),
        .presetn    (presetn),
        .data_wr    (wr && sel == gpjn_sel_l_data),
        .dir_wr     (wr && sel == gpjn_sel_l_dir),
        .wdata      (pwdata[7:0]),
        .pin_in     (port_l_pin_in),
        .alt_sel    (8'h00),
        .alt_out    (8'h00),
        .stop_float (stop_float),
        .rd_data    (l_rd),
        .dir        (port_l_direction),
        .pin_out    (port_l_pin_out),
        .pin_oe     (port_l_pin_oe)
    );

    gpjn_port_slice #(.W(8)) u_port_m (
        .pclk       (pclk),
        .presetn    (presetn),
        .data_wr    (wr && sel == gpjn_sel_m_data),
        .dir_wr     (wr && sel == gpjn_sel_m_dir),
        .wdata      (pwdata[7:0]),
        .pin_in     (port_m_pin_in),
        .alt_sel    (8'h00),
        .alt_out    (8'h00),
        .stop_float (stop_float),
        .rd_data    (m_rd),
        .dir        (port_m_direction),
        .pin_out    (port_m_pin_out),
        .pin_oe     (port_m_pin_oe)
    );

    gpjn_port_slice #(.W(8)) u_port_n (
        .pclk       (pclk),
        .presetn    (presetn),
        .data_wr    (wr && sel == gpjn_sel_n_data),
        .dir_wr     (wr && sel == gpjn_sel_n_dir),
        .wdata      (pwdata[7:0]),
        .pin_in     (port_n_pin_in),
        .alt_sel    (8'h00),
        .alt_out    (8'h00),
        .stop_float (stop_float),
        .rd_data    (n_rd),
        .dir        (port_n_direction),
        .pin_out    (port_n_pin_out),
        .pin_oe     (port_n_pin_oe)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_ready_timing_a: assert property (
        psel && !penable |=> pready ##1 !pready
    ) else $error("ready not a single access cycle pulse");

    unmapped_error_a: assert property (
        psel && !penable && sel == gpjn_sel_none |=> pslverr && prdata == 32'h0000_0000
    ) else $error("unmapped access not flagged");

    dma_f_priority_a: assert property (
        port_f_dma_claim[0] && port_f_dma_claim[2] |=> dma_request_ch2_in && dma_request_ch3_in
    ) else $error("port J kept dma request claimed by port F");

    dma_request_route_a: assert property (
        port_j_alt_function[0] && !port_f_dma_claim[0]
            |=> dma_request_ch2_in == $past(port_j_pin_in[0])
    ) else $error("dma request not routed from port J");

    dma_ack_route_a: assert property (
        j_alt_sel[3] |=> port_j_pin_out[3] == $past(dma_acknowledge_ch3_out)
    ) else $error("dma acknowledge not driven on port J");

    key_route_a: assert property (
        1'b1 |=> wake_switch_input ==
            $past((port_k_alt_function & port_k_pin_in) | ~port_k_alt_function)
    ) else $error("key input routing wrong");

    pullup_port_off_a: assert property (
        port_k_alt_function == 8'h00 |=> port_k_pullup_on == 8'h00
    ) else $error("pull-up on while port K used as port");

    pullup_condition_a: assert property (
        ##1 (port_k_pullup_on & ~$past(wake_pullup_enable & wake_input_setting)) == 8'h00
    ) else $error("pull-up on without enable and wake setting");

    stop_float_a: assert property (
        (stop_mode && !stop_drive_enable) [*2]
            |=> port_l_pin_oe == 8'h00 && port_m_pin_oe == 8'h00 && port_n_pin_oe == 8'h00
    ) else $error("driver enabled in stop without drive enable");

    read_mix_a: assert property (
        psel && !penable && sel == gpjn_sel_l_data |=> prdata[7:0] == $past(l_rd)
            && ((prdata[7:0] ^ $past(port_l_pin_in)) & ~$past(port_l_direction)) == 8'h00
    ) else $error("input bit read does not show pin level");

    dma_routed_c: cover property (j_alt_sel[0] ##1 !dma_request_ch2_in);
    pullup_on_c: cover property (port_k_pullup_on != 8'h00);
    stop_float_c: cover property (stop_float && port_l_direction != 8'h00);
    unmapped_c: cover property (pslverr && pready);

endmodule // gpjn_ports

// *** gpjn_pin_model.sv ***
// Purpose: outside world of one port: resolves each pin from both drivers
// Assumes: the bench supplies the level an outside device puts on each pin
// Notes: a pin the block drives shows the block's value, else the outside one
`timescale 1ns/1ps

module gpjn_pin_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] ext,
    output logic      [W-1:0] pin_in
);
    // wire level from the block's enable and the outside driver
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // gpjn_pin_model

// *** gpjn_ports_tb_top.sv ***
// Purpose: register and pin tests of the port J to N block
// Assumes: wait-free APB slave, pins and pull-ups lag a write by one cycle
// Notes: byte address is four times the register index
`timescale 1ns/1ps

module gpjn_ports_tb_top;
    import gpjn_pkg::*;
    logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]   paddr = 0;
    logic [31:0]   pwdata = 0, prdata, rv;
    logic [3:0]    pstrb = 4'hf, port_f_dma_claim = 0, ext_j = 0;
    logic [3:0]    port_j_pin_in, port_j_pin_out, port_j_pin_oe;
    logic          pready, pslverr, re, stop_mode = 0;
    logic          dma_acknowledge_ch2_out = 1, dma_acknowledge_ch3_out = 1;
    logic          dma_request_ch2_in, dma_request_ch3_in;
    gpjn_byte_type port_k_pin_in, port_k_pin_out, port_k_pin_oe, ext_k = 0;
    gpjn_byte_type port_l_pin_in, port_l_pin_out, port_l_pin_oe, ext_l = 0;
    gpjn_byte_type port_m_pin_in, port_m_pin_out, port_m_pin_oe, ext_m = 0;
    gpjn_byte_type port_n_pin_in, port_n_pin_out, port_n_pin_oe, ext_n = 8'h96;
    gpjn_byte_type wake_pullup_enable = 0, wake_input_setting = 0;
    gpjn_byte_type wake_switch_input, port_k_pullup_on;
    int            fail_count = 0, checks = 0;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    gpjn_ports i_gpjn_ports (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_j_pin_in, .port_j_pin_out,
        .port_j_pin_oe, .port_k_pin_in, .port_k_pin_out, .port_k_pin_oe, .port_l_pin_in,
        .port_l_pin_out, .port_l_pin_oe, .port_m_pin_in, .port_m_pin_out, .port_m_pin_oe,
        .port_n_pin_in, .port_n_pin_out, .port_n_pin_oe, .stop_mode, .port_f_dma_claim,
        .dma_acknowledge_ch2_out, .dma_acknowledge_ch3_out, .dma_request_ch2_in,
        .dma_request_ch3_in, .wake_pullup_enable, .wake_input_setting, .wake_switch_input,
        .port_k_pullup_on);

    // outside drivers of every port
    gpjn_pin_model #(4) i_pm_j (.pin_out(port_j_pin_out), .pin_oe(port_j_pin_oe),
        .ext(ext_j), .pin_in(port_j_pin_in));
    gpjn_pin_model #(8) i_pm_k (.pin_out(port_k_pin_out), .pin_oe(port_k_pin_oe),
        .ext(ext_k), .pin_in(port_k_pin_in));
    gpjn_pin_model #(8) i_pm_l (.pin_out(port_l_pin_out), .pin_oe(port_l_pin_oe),
        .ext(ext_l), .pin_in(port_l_pin_in));
    gpjn_pin_model #(8) i_pm_m (.pin_out(port_m_pin_out), .pin_oe(port_m_pin_oe),
        .ext(ext_m), .pin_in(port_m_pin_in));
    gpjn_pin_model #(8) i_pm_n (.pin_out(port_n_pin_out), .pin_oe(port_n_pin_oe),
        .ext(ext_n), .pin_in(port_n_pin_in));

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one APB transfer, result in rv and re
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 0, 1);
        rv = prdata;
        re = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        xfer(0, a, 0);
        chk($sformatf("read %h", a), rv, {24'h0, e});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    // verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        final_report;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        // reset state
        rd(12'h1d4, 8'h00);
        rd(12'h1e4, 8'h00);
        rd(12'h310, 8'h00);
        rd(12'h314, 8'h00);
        rd(12'h318, 8'h00);
        chk("k oe", port_k_pin_oe, 0);
        done("reset");
        // latch written while input, shown once output
        ext_l <= 8'h3c;
        rd(12'h300, 8'h3c);
        wr(12'h300, 8'h5a);
        rd(12'h300, 8'h3c);
        wr(12'h310, 8'hff);
        tick(2);
        chk("l out", port_l_pin_out, 8'h5a);
        chk("l oe", port_l_pin_oe, 8'hff);
        rd(12'h300, 8'h5a);
        // latch written while already an output
        wr(12'h300, 8'hc3);
        rd(12'h300, 8'hc3);
        // mixed directions, latch still at reset ones
        ext_m <= 8'ha5;
        wr(12'h314, 8'h0f);
        tick(2);
        chk("m out", port_m_pin_out, 8'hff);
        chk("m oe", port_m_pin_oe, 8'h0f);
        rd(12'h304, 8'haf);
        wr(12'h318, 8'h81);
        rd(12'h318, 8'h81);
        rd(12'h308, 8'h97);
        chk("n oe", port_n_pin_oe, 8'h81);
        chk("n out", port_n_pin_out, 8'hff);
        wr(12'h1d4, 8'hff);
        tick(2);
        chk("k out", port_k_pin_out, 8'hff);
        chk("k oe", port_k_pin_oe, 8'hff);
        wr(12'h1d4, 8'h00);
        done("direction");
        // key inputs and pull-ups
        ext_k <= 8'h55;
        wake_pullup_enable <= 8'h33;
        wake_input_setting <= 8'hff;
        wr(12'h1e4, 8'h0f);
        tick(2);
        chk("key", wake_switch_input, 8'hf5);
        chk("pullup", port_k_pullup_on, 8'h03);
        rd(12'h1c4, 8'h55);
        done("key");
        // DMA routing on port J
        dma_acknowledge_ch2_out <= 0;
        wr(12'h1d0, 8'h0a);
        wr(12'h1e0, 8'hff);
        rd(12'h1e0, 8'h0f);
        tick(2);
        chk("req2", dma_request_ch2_in, 0);
        chk("req3", dma_request_ch3_in, 0);
        chk("j oe", port_j_pin_oe, 4'ha);
        chk("ack", {port_j_pin_out[3], port_j_pin_out[1]}, 2'b10);
        rd(12'h1c0, 8'h0a);
        port_f_dma_claim <= 4'h5;
        tick(2);
        chk("req2 f", dma_request_ch2_in, 1);
        chk("req3 f", dma_request_ch3_in, 1);
        done("dma");
        // stop mode drive control
        stop_mode <= 1;
        tick(2);
        chk("stop oe", port_l_pin_oe, 8'h00);
        chk("stop n oe", port_n_pin_oe, 8'h00);
        wr(12'h3e0, 8'h01);
        tick(2);
        chk("drive oe", port_l_pin_oe, 8'hff);
        stop_mode <= 0;
        done("stop");
        // refusals
        xfer(1, 12'h3fc, 32'hff);
        chk("slverr", re, 1);
        pstrb <= 4'h0;
        wr(12'h318, 8'h00);
        pstrb <= 4'hf;
        rd(12'h318, 8'h81);
        done("refuse");
        final_report;
    end
endmodule // gpjn_ports_tb_top
